//--- include/laser_pkg.sv
// Constants, register map and types of the gated laser pulse controller
package laser_pkg;

  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_INT = 2'b01,
    MODE_EXT = 2'b10,
    MODE_RSV = 2'b11
  } mode_t;

  // Pulse timer runs on CLK
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned MIN_WIDTH_NS = 300;
  localparam int unsigned MIN_WIDTH_CYC = (MIN_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ON_LIMIT_MS = 50;
  localparam int unsigned ON_LIMIT_CYC = (ON_LIMIT_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned ON_CNT_W = 20;

  // Register byte addresses
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] PERIOD_OFF = 8'h04;
  localparam logic [7:0] WIDTH_OFF = 8'h08;
  localparam logic [7:0] CURLIM_OFF = 8'h0C;
  localparam logic [7:0] STATUS_OFF = 8'h10;

  // Field positions
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_CLEAR_BIT = 8;
  localparam int unsigned ST_OV_BIT = 0;
  localparam int unsigned ST_UV_BIT = 1;
  localparam int unsigned ST_OC_BIT = 2;
  localparam int unsigned ST_TRIP_BIT = 3;
  localparam int unsigned ST_ON_BIT = 4;
  localparam int unsigned ST_GATE_BIT = 5;
  localparam int unsigned ST_RUN_BIT = 6;

  // Reset values and built-in current ceiling
  localparam logic [15:0] PERIOD_RST = 16'h0064;
  localparam logic [15:0] WIDTH_RST = 16'h0003;
  localparam logic [15:0] CURLIM_RST = 16'h0000;
  localparam logic [15:0] CURRENT_CEILING = 16'h8000;

endpackage : laser_pkg

//--- core/gate_sync.sv
// Two-stage synchroniser for asynchronous level inputs
`timescale 1ns/1ps
`default_nettype none
module gate_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule : gate_sync
`default_nettype wire

//--- core/gated_laser_pulse_control.sv
// Pulse generator, permit gating, on-time limit and fault latch with APB registers
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Output only with arm and safety permits
// - Laser-on line copies active modulation
// - External mode: pulses only while gate high
// - Gate is envelope; internal settings shape pulses
// - Width at least period gives continuous on
// - Gate over 50 ms forces off till low
// - Any on-time over 50 ms shuts output
// - Status faults stop the laser-on line
// - Fault indicator high while fault blocks output
// - Faults latch until software clear
// - Ready when idle, running in internal/external mode or faulted
// - External mode uses only user current limit
// - Modes off, internal (min 300 ns), external
// - Pulse timer free-runs, unsynced to gate
// - Period and width in timer cycles
// - Stored settings restored at power up
module gated_laser_pulse_control import laser_pkg::*; #(
  parameter int unsigned ON_LIMIT = ON_LIMIT_CYC
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Stored settings sampled after reset
  input wire logic [1:0] STORED_MODE,
  input wire logic [15:0] STORED_PERIOD,
  input wire logic [15:0] STORED_WIDTH,
  input wire logic [15:0] STORED_CURLIM,
  // Permits, gate and supervision
  input wire logic SUPPLY_REGULATOR_PERMIT,
  input wire logic ARM_PERMIT,
  input wire logic SAFETY_PERMIT,
  input wire logic EXTERNAL_GATE_IN,
  input wire logic OVERVOLTAGE,
  input wire logic UNDERVOLTAGE,
  input wire logic [15:0] PULSE_CURRENT,
  // Drive and indicators
  output logic LASER_ON,
  output logic FAULT_IND,
  output logic READY_IND,
  output logic RUNNING_IND
);

  mode_t mode_reg;
  logic [15:0] period_reg;
  logic [15:0] width_reg;
  logic [15:0] curlim_reg;
  logic boot_reg;
  logic [2:0] fault_reg;
  logic [2:0] fault_next;
  logic [15:0] cnt_reg;
  logic [ON_CNT_W-1:0] on_cnt_reg;
  logic trip_reg;
  logic gate_s;
  logic clr_pulse;
  logic wr_en;
  logic setup;
  logic [15:0] width_eff;
  logic [15:0] limit_eff;
  logic cw;
  logic raw_pulse;
  logic src_on;
  logic track;
  logic permits;
  logic drive_next;
  logic oc_det;
  logic at_limit;
  logic [31:0] rdata_next;
  logic map_hit;

  // Asynchronous gate taken into CLK domain
  gate_sync #(.W(1)) u_gate_sync (
    .clk(CLK),
    .resetn(RESETN),
    .d(EXTERNAL_GATE_IN),
    .q(gate_s)
  );

  // APB: setup cycle registers the answer, access cycle completes
  assign setup = PSEL && !PENABLE;
  assign wr_en = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
  assign clr_pulse = wr_en && (PADDR == CTRL_OFF) && PWDATA[CTRL_CLEAR_BIT];

  always_comb begin
    map_hit = 1'b1;
    rdata_next = 32'h0000_0000;
    case (PADDR)
      CTRL_OFF: rdata_next[CTRL_MODE_LSB +: 2] = mode_reg;
      PERIOD_OFF: rdata_next[15:0] = period_reg;
      WIDTH_OFF: rdata_next[15:0] = width_reg;
      CURLIM_OFF: rdata_next[15:0] = curlim_reg;
      STATUS_OFF: begin
        rdata_next[ST_OV_BIT] = fault_reg[0];
        rdata_next[ST_UV_BIT] = fault_reg[1];
        rdata_next[ST_OC_BIT] = fault_reg[2];
        rdata_next[ST_TRIP_BIT] = trip_reg;
        rdata_next[ST_ON_BIT] = LASER_ON;
        rdata_next[ST_GATE_BIT] = gate_s;
        rdata_next[ST_RUN_BIT] = RUNNING_IND;
      end
      default: map_hit = 1'b0;
    endcase
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
    end else begin
      PREADY <= setup;
      if (setup) begin
        PSLVERR <= !map_hit;
        PRDATA <= PWRITE ? 32'h0000_0000 : rdata_next;
      end
    end
  end

  // Settings: stored copy loaded once, then software writes
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      boot_reg <= 1'b1;
      mode_reg <= MODE_OFF;
      period_reg <= PERIOD_RST;
      width_reg <= WIDTH_RST;
      curlim_reg <= CURLIM_RST;
    end else if (boot_reg) begin
      boot_reg <= 1'b0;
      mode_reg <= mode_t'(STORED_MODE);
      period_reg <= STORED_PERIOD;
      width_reg <= STORED_WIDTH;
      curlim_reg <= STORED_CURLIM;
    end else if (wr_en) begin
      case (PADDR)
        CTRL_OFF: mode_reg <= mode_t'(PWDATA[CTRL_MODE_LSB +: 2]);
        PERIOD_OFF: period_reg <= PWDATA[15:0];
        WIDTH_OFF: width_reg <= PWDATA[15:0];
        CURLIM_OFF: curlim_reg <= PWDATA[15:0];
        default: ;
      endcase
    end
  end

  // Free-running period counter, never restarted by the gate
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      cnt_reg <= 16'h0000;
    end else if (cnt_reg >= period_reg - 16'h0001 || period_reg == 16'h0000) begin
      cnt_reg <= 16'h0000;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  // Internal mode never pulses narrower than the floor
  assign width_eff = (mode_reg == MODE_INT && width_reg < 16'(MIN_WIDTH_CYC)) ?
                     16'(MIN_WIDTH_CYC) : width_reg;
  assign cw = width_eff >= period_reg;
  assign raw_pulse = cw || (cnt_reg < width_eff);

  // One source per mode; code 3 behaves as off
  always_comb begin
    case (mode_reg)
      MODE_INT: src_on = raw_pulse;
      MODE_EXT: src_on = raw_pulse && gate_s;
      default: src_on = 1'b0;
    endcase
  end

  // External mode times the gate, others the pulse itself
  assign track = (mode_reg == MODE_EXT) ? gate_s : src_on;
  assign at_limit = track && (on_cnt_reg >= ON_CNT_W'(ON_LIMIT - 1));

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      on_cnt_reg <= '0;
    end else if (!track) begin
      on_cnt_reg <= '0;
    end else if (!at_limit) begin
      on_cnt_reg <= on_cnt_reg + 1'b1;
    end
  end

  // Trip held until the gate or the pulse falls
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      trip_reg <= 1'b0;
    end else if (at_limit) begin
      trip_reg <= 1'b1;
    end else if (!track) begin
      trip_reg <= 1'b0;
    end
  end

  // Built-in ceiling applies outside external mode only
  assign limit_eff = (mode_reg == MODE_EXT || curlim_reg < CURRENT_CEILING) ?
                     curlim_reg : CURRENT_CEILING;
  assign oc_det = LASER_ON && (PULSE_CURRENT > limit_eff);

  // New fault events beat a clear in the same cycle
  always_comb begin
    fault_next = clr_pulse ? 3'h0 : fault_reg;
    fault_next = fault_next | {oc_det, UNDERVOLTAGE, OVERVOLTAGE};
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      fault_reg <= 3'h0;
    end else begin
      fault_reg <= fault_next;
    end
  end

  assign permits = ARM_PERMIT && SAFETY_PERMIT && SUPPLY_REGULATOR_PERMIT;
  assign drive_next = src_on && permits && !trip_reg && !at_limit &&
                      (fault_next == 3'h0);

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      LASER_ON <= 1'b0;
    end else begin
      LASER_ON <= drive_next;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      FAULT_IND <= 1'b0;
      READY_IND <= 1'b0;
      RUNNING_IND <= 1'b0;
    end else begin
      FAULT_IND <= fault_next != 3'h0;
      RUNNING_IND <= (mode_reg == MODE_INT || mode_reg == MODE_EXT) ||
                     fault_next != 3'h0;
      READY_IND <= !((mode_reg == MODE_INT || mode_reg == MODE_EXT) ||
                     fault_next != 3'h0);
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);

  permit_block_a: assert property (
    !(ARM_PERMIT && SAFETY_PERMIT) |=> !LASER_ON
  ) else $error("output with a permit low");

  fault_block_a: assert property (
    fault_reg != 3'h0 && !clr_pulse |=> !LASER_ON ##1 (!LASER_ON || $past(clr_pulse))
  ) else $error("output during status fault");

  fault_ind_a: assert property (
    $rose(fault_reg != 3'h0) |-> FAULT_IND && !READY_IND
  ) else $error("fault indicator not raised");

  fault_hold_a: assert property (
    fault_reg != 3'h0 && !clr_pulse |=> fault_reg != 3'h0 && FAULT_IND
  ) else $error("fault dropped without clear");

  ext_gate_a: assert property (
    mode_reg == MODE_EXT && !gate_s |=> !LASER_ON
  ) else $error("external mode output with gate low");

  cw_follow_a: assert property (
    mode_reg == MODE_EXT && cw && gate_s && permits && !trip_reg && !at_limit &&
    fault_next == 3'h0 |=> LASER_ON
  ) else $error("continuous setting not following gate");

  limit_trip_a: assert property (
    at_limit |=> trip_reg && !LASER_ON
  ) else $error("on-time limit not enforced");

  trip_hold_a: assert property (
    trip_reg && mode_reg == MODE_EXT && gate_s |=> trip_reg ##1 !LASER_ON
  ) else $error("trip released while gate high");

  run_ind_a: assert property (
    mode_reg == MODE_OFF && fault_next == 3'h0 |=> READY_IND && !RUNNING_IND
  ) else $error("idle not shown as ready");

  min_width_a: assert property (
    mode_reg == MODE_INT && !cw && $rose(raw_pulse) && $stable(width_reg) |->
    raw_pulse[*3]
  ) else $error("internal pulse shorter than floor");

  wrap_a: assert property (
    period_reg != 16'h0000 && cnt_reg == period_reg - 16'h0001 && $stable(period_reg)
    |=> cnt_reg == 16'h0000
  ) else $error("period counter wrap wrong");

  on_cnt_a: assert property (
    !track |=> on_cnt_reg == '0
  ) else $error("on-time counter not restarted");

endmodule : gated_laser_pulse_control
`default_nettype wire

//--- bench/laser_far_side.sv
// Far-side model: gate source and permit wiring of the driver arms
`timescale 1ns/1ps
`default_nettype none
module laser_far_side (
  // Controls from the bench
  input wire logic ext_sel,
  input wire logic gate_req,
  input wire logic arm_ok,
  // Lines into the device
  output logic gate_out,
  output logic reg_permit,
  output logic arm_permit,
  output logic safety_permit
);
  // No cable: regulator and safety permits tied high by the far side, arm permit follows arm_ok
  assign reg_permit = 1'b1;
  assign safety_permit = 1'b1;
  assign arm_permit = arm_ok;
  // Gate left disconnected, pulled low, outside external mode
  assign gate_out = ext_sel & gate_req;
endmodule : laser_far_side
`default_nettype wire

//--- bench/gated_laser_pulse_control_tb.sv
// Testbench for the gated laser pulse controller
`timescale 1ns/1ps
`default_nettype none
module gated_laser_pulse_control_tb import laser_pkg::*;;
  logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, e, ov = 0, uv = 0, ext_sel = 0, gate_req = 0, arm_ok = 1;
  logic [15:0] current = 16'h0000;
  logic gate, regp, armp, safp, laser_on, fault_ind, ready_ind, running_ind;
  int fail_count = 0, n_compared = 0, cyc = 0, k;
  always #50 clk = ~clk;
  laser_far_side u_far (.ext_sel(ext_sel), .gate_req(gate_req), .arm_ok(arm_ok),
    .gate_out(gate), .reg_permit(regp), .arm_permit(armp), .safety_permit(safp));
  gated_laser_pulse_control #(.ON_LIMIT(20)) u_dut (.CLK(clk), .RESETN(resetn),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .STORED_MODE(2'h0),
    .STORED_PERIOD(16'h000A), .STORED_WIDTH(16'h0003), .STORED_CURLIM(16'h0000),
    .SUPPLY_REGULATOR_PERMIT(regp), .ARM_PERMIT(armp), .SAFETY_PERMIT(safp),
    .EXTERNAL_GATE_IN(gate), .OVERVOLTAGE(ov), .UNDERVOLTAGE(uv), .PULSE_CURRENT(current),
    .LASER_ON(laser_on), .FAULT_IND(fault_ind), .READY_IND(ready_ind),
    .RUNNING_IND(running_ind));
  task end_sim;
    if (fail_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      end_sim();
    end
  end
  task chk(input string s, input logic [31:0] x, input logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", s, x, g);
    end
  endtask : chk
  // Setup, access held until pready seen high at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task cnt_on(input int n);
    k = 0;
    repeat (n) begin
      @(negedge clk);
      if (laser_on === 1'b1) k++;
    end
  endtask : cnt_on
  task wait_c(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_c
  initial begin
    wait_c(10);
    resetn <= 1;
    wait_c(2);
    apb(0, PERIOD_OFF, 0); chk("period", 32'h0000000A, r);
    apb(0, 8'h20, 0); chk("slverr", 1, e);
    apb(1, CTRL_OFF, 32'h1);
    // First cycle after the write still shows the old mode
    wait_c(1);
    cnt_on(20); chk("int on", 6, k);
    chk("running", 1, running_ind);
    apb(1, WIDTH_OFF, 32'h1);
    cnt_on(20); chk("min width", 6, k);
    @(posedge clk) arm_ok <= 0;
    wait_c(1);
    cnt_on(20); chk("arm off", 0, k);
    @(posedge clk) arm_ok <= 1;
    apb(1, WIDTH_OFF, 32'hA);
    wait_c(3);
    cnt_on(10); chk("cw", 10, k);
    wait_c(20);
    cnt_on(5); chk("trip", 0, k);
    apb(0, STATUS_OFF, 0); chk("trip bit", 1, r[ST_TRIP_BIT]);
    apb(1, CTRL_OFF, 32'h0);
    wait_c(3);
    @(negedge clk);
    chk("ready", 1, ready_ind);
    apb(1, CURLIM_OFF, 32'h9000);
    apb(1, CTRL_OFF, 32'h2);
    @(posedge clk) begin
      ext_sel <= 1;
      current <= 16'h8800;
    end
    cnt_on(10); chk("gate low", 0, k);
    @(posedge clk) gate_req <= 1;
    wait_c(5);
    cnt_on(8); chk("envelope", 8, k);
    chk("no ceiling", 0, fault_ind);
    wait_c(20);
    cnt_on(5); chk("gate limit", 0, k);
    @(posedge clk) gate_req <= 0;
    wait_c(5);
    gate_req <= 1;
    wait_c(5);
    @(negedge clk);
    chk("rearm", 1, laser_on);
    @(posedge clk) current <= 16'h9001;
    wait_c(3);
    @(negedge clk);
    chk("oc off", 0, laser_on);
    chk("fault", 1, fault_ind);
    chk("run flt", 1, running_ind);
    @(posedge clk) begin
      current <= 16'h0000;
      gate_req <= 0;
      ext_sel <= 0;
    end
    apb(1, WIDTH_OFF, 32'h3);
    apb(1, CTRL_OFF, 32'h1);
    cnt_on(20); chk("latched", 0, k);
    apb(1, CTRL_OFF, 32'h101);
    cnt_on(20); chk("cleared", 6, k);
    chk("flt low", 0, fault_ind);
    @(posedge clk) begin
      ov <= 1;
      uv <= 1;
    end
    @(posedge clk) begin
      ov <= 0;
      uv <= 0;
    end
    wait_c(3);
    @(negedge clk);
    chk("ovuv", 1, fault_ind);
    apb(0, STATUS_OFF, 0); chk("status", 3, r[1:0]);
    // Clear and go to external mode with short pulses inside the gate
    apb(1, CTRL_OFF, 32'h102);
    @(posedge clk) begin
      ext_sel <= 1;
      gate_req <= 1;
    end
    wait_c(3);
    cnt_on(10); chk("gated pulses", 3, k);
    @(posedge clk) begin
      gate_req <= 0;
      ext_sel <= 0;
    end
    apb(1, CTRL_OFF, 32'h3);
    wait_c(2);
    @(negedge clk);
    chk("mode 3 ready", 1, ready_ind);
    chk("mode 3 off", 0, laser_on);
    end_sim();
  end
endmodule : gated_laser_pulse_control_tb
`default_nettype wire
